// >>> rtl/memory_map_decoder.sv
// memory map decoder: routes cpu fetches and data accesses to regions,
// enforces flash protection and times flash program/erase operations
// assumes: the flash array returns 64-bit ecc-corrected lines in one cycle;
// protection inputs come from logic on the same clock
//
// Functional notes
// - 16 Mbyte map, 64K segments, 16K pages
// - byte or word access anywhere mapped
// - data ram and register areas in segment 0
// - fetches go only through program unit
// - data transfers go through data unit
// - units exchange data over system bus
// - flash from c00000, size per variant
// - program sram e00000 to e007ff
// - data sram from 00c000 per variant
// - dual port ram, top 256 bytes bit addressable
// - 16 word registers or byte pairs
// - two 512-byte register areas decoded
// - undefined flash registers read trap code
// - 8K and 32K sectors, 128-byte blocks
// - small sectors protected in pairs
// - read protection lifted by password unlock
// - 64-bit single-cycle reads, error corrected
// - program max 5 ms, erase max 500 ms
`timescale 1ns/1ns
module memory_map_decoder #(
  parameter int prog_count = memory_map_pkg::prog_cycles,
  parameter int erase_count = memory_map_pkg::erase_cycles
)(
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // variant and protection setup
  input wire memory_map_pkg::flash_size_e flash_size,
  input wire memory_map_pkg::data_sram_size_e data_sram_size,
  input wire logic read_protect,
  input wire logic [4:0] write_protect,
  input wire logic unlocked,
  // cpu request and answer
  input wire memory_map_pkg::cpu_req_s req,
  output memory_map_pkg::cpu_rsp_s rsp,
  output logic busy,
  // routing view
  output memory_map_pkg::route_s route,
  output logic [7:0] segment,
  output logic [1:0] data_page,
  output logic [3:0] gpr_index,
  output logic gpr_high_byte,
  // flash array and register side
  input wire logic [63:0] flash_line,
  input wire logic [15:0] flash_reg_rdata,
  input wire logic flash_reg_defined,
  input wire logic [15:0] local_rdata,
  output logic [16:0] flash_block_addr
);

  // ----------------------------------------------------------------
  // region decode
  // ----------------------------------------------------------------
  function automatic logic in_range(input logic [23:0] a,
    input logic [23:0] lo, input logic [23:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction

  function automatic logic [23:0] flash_top(
    input memory_map_pkg::flash_size_e s);
    unique case (s)
      memory_map_pkg::size_32k: flash_top = memory_map_pkg::flash_end_32k;
      memory_map_pkg::size_64k: flash_top = memory_map_pkg::flash_end_64k;
      default: flash_top = memory_map_pkg::flash_end_128k;
    endcase
  endfunction

  memory_map_pkg::region_e region;
  logic [23:0] data_sram_top;
  logic data_sram_present;
  logic [2:0] sector;

  always_comb
  begin
    data_sram_present = (data_sram_size != memory_map_pkg::data_sram_0k);
    data_sram_top = (data_sram_size == memory_map_pkg::data_sram_2k) ?
      memory_map_pkg::data_sram_end_2k : memory_map_pkg::data_sram_end;
    region = memory_map_pkg::reg_none;
    if (in_range(req.addr, memory_map_pkg::flash_reg_base,
        memory_map_pkg::flash_reg_end))
      region = memory_map_pkg::reg_flash_regs;
    else if (in_range(req.addr, memory_map_pkg::flash_base,
        flash_top(flash_size)))
      region = memory_map_pkg::reg_flash;
    else if (in_range(req.addr, memory_map_pkg::program_sram_base,
        memory_map_pkg::program_sram_end))
      region = memory_map_pkg::reg_program_sram;
    else if (data_sram_present && in_range(req.addr,
        memory_map_pkg::data_sram_base, data_sram_top))
      region = memory_map_pkg::reg_data_sram;
    else if (in_range(req.addr, memory_map_pkg::dual_port_ram_base,
        memory_map_pkg::dual_port_ram_end))
      region = memory_map_pkg::reg_dual_port_ram;
    else if (in_range(req.addr, memory_map_pkg::sfr_base,
        memory_map_pkg::sfr_end) || in_range(req.addr,
        memory_map_pkg::extended_special_register_area_base, memory_map_pkg::extended_special_register_area_end))
      region = (req.addr[11]) ? memory_map_pkg::reg_sfr :
        memory_map_pkg::reg_extended_special_register_area;
    else if (req.addr[23:11] == 13'h0400)
      region = memory_map_pkg::reg_periph_bus;
    // sector: four 8K then 32K sectors
    if (req.addr <= memory_map_pkg::small_area_end)
      sector = {1'b0, req.addr[14:13]};
    else
      sector = 3'h3 + {1'b0, req.addr[16:15]};
  end

  // segment and page split, gpr byte view
  always_comb
  begin
    segment = req.addr[23:memory_map_pkg::seg_lsb];
    data_page = req.addr[15:memory_map_pkg::page_lsb];
    gpr_index = req.addr[4:1];
    gpr_high_byte = req.addr[0] & ~req.word;
  end

  // fetch path owns flash and program_sram; data unit owns the rest
  logic fetch_illegal;
  logic prot_read_block;
  logic prot_write_block;
  logic [2:0] prot_group;
  always_comb
  begin
    fetch_illegal = req.fetch && !(region == memory_map_pkg::reg_flash ||
      region == memory_map_pkg::reg_program_sram);
    prot_group = (sector < 3'h4) ? {2'b00, sector[1]} : sector - 3'h2;
    prot_read_block = (region == memory_map_pkg::reg_flash) &&
      read_protect && !unlocked;
    prot_write_block = (region == memory_map_pkg::reg_flash) &&
      req.op != memory_map_pkg::op_read &&
      write_protect[prot_group] && !unlocked;
    route.region = region;
    route.sector = sector;
    route.bit_addr = (region == memory_map_pkg::reg_dual_port_ram &&
      req.addr >= memory_map_pkg::dual_port_ram_bit_base) ||
      region == memory_map_pkg::reg_sfr ||
      region == memory_map_pkg::reg_extended_special_register_area;
    route.data_unit = !req.fetch;
    route.via_system_bus = !req.fetch && (region ==
      memory_map_pkg::reg_flash || region == memory_map_pkg::reg_program_sram ||
      region == memory_map_pkg::reg_periph_bus);
  end

  // ----------------------------------------------------------------
  // access sequencing and flash timing
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {st_idle, st_flash_op} state_e;
  state_e state;
  state_e next_state;
  logic [22:0] timer;
  logic [22:0] next_timer;
  memory_map_pkg::cpu_rsp_s next_rsp;
  logic [16:0] next_block_addr;
  logic [15:0] lane;

  always_comb
  begin
    // pick the 16-bit lane out of the ecc-corrected 64-bit line
    unique case (req.addr[2:1])
      2'h0: lane = flash_line[15:0];
      2'h1: lane = flash_line[31:16];
      2'h2: lane = flash_line[47:32];
      default: lane = flash_line[63:48];
    endcase
    next_state = state;
    next_timer = timer;
    next_block_addr = flash_block_addr;
    next_rsp = '0;
    unique case (state)
      st_idle:
        if (req.valid)
        begin
          if (region == memory_map_pkg::reg_none || fetch_illegal ||
              prot_read_block || prot_write_block ||
              (req.op inside {memory_map_pkg::op_erase,
              memory_map_pkg::op_program} &&
              region != memory_map_pkg::reg_flash))
          begin
            next_rsp.done = 1'b1;
            next_rsp.trap = 1'b1;
          end
          else if (req.op == memory_map_pkg::op_program)
          begin
            next_block_addr = req.addr[23:block_shift()];
            next_timer = 23'(prog_count - 1);
            next_state = st_flash_op;
          end
          else if (req.op == memory_map_pkg::op_erase)
          begin
            next_block_addr = req.addr[23:block_shift()];
            next_timer = 23'(erase_count - 1);
            next_state = st_flash_op;
          end
          else
          begin
            next_rsp.done = 1'b1;
            if (req.op == memory_map_pkg::op_read)
            begin
              if (region == memory_map_pkg::reg_flash)
                next_rsp.rdata = lane;
              else if (region == memory_map_pkg::reg_flash_regs)
                next_rsp.rdata = flash_reg_defined ? flash_reg_rdata :
                  memory_map_pkg::trap_code;
              else
                next_rsp.rdata = local_rdata;
              if (!req.word)
                next_rsp.rdata = {8'h00, req.addr[0] ?
                  next_rsp.rdata[15:8] : next_rsp.rdata[7:0]};
            end
          end
        end
      st_flash_op:
        if (timer == 23'h0)
        begin
          next_rsp.done = 1'b1;
          next_state = st_idle;
        end
        else
          next_timer = timer - 23'h1;
      default:
        next_state = st_idle;
    endcase
  end

  function automatic int block_shift();
    block_shift = memory_map_pkg::block_lsb;
  endfunction

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      state <= st_idle;
      timer <= '0;
      rsp <= '0;
      flash_block_addr <= '0;
    end
    else
    begin
      state <= next_state;
      timer <= next_timer;
      rsp <= next_rsp;
      flash_block_addr <= next_block_addr;
    end
  end

  assign busy = (state == st_flash_op);

endmodule

// >>> rtl/memory_map_pkg.sv
// memory map constants, region codes and request/response carriers
// assumes a 24-bit linear byte address and a single cpu clock
package memory_map_pkg;

  // address space geometry
  localparam int addr_w = 24;
  localparam int seg_lsb = 16;
  localparam int page_lsb = 14;

  // region bounds
  localparam logic [23:0] flash_base = 24'hc0_0000;
  localparam logic [23:0] flash_end_128k = 24'hc1_ffff;
  localparam logic [23:0] flash_end_64k = 24'hc0_ffff;
  localparam logic [23:0] flash_end_32k = 24'hc0_7fff;
  localparam logic [23:0] program_sram_base = 24'he0_0000;
  localparam logic [23:0] program_sram_end = 24'he0_07ff;
  localparam logic [23:0] data_sram_base = 24'h00_c000;
  localparam logic [23:0] data_sram_end = 24'h00_cfff;
  localparam logic [23:0] dual_port_ram_base = 24'h00_f600;
  localparam logic [23:0] dual_port_ram_end = 24'h00_fdff;
  localparam logic [23:0] dual_port_ram_bit_base = 24'h00_fd00;
  localparam logic [23:0] sfr_base = 24'h00_fe00;
  localparam logic [23:0] sfr_end = 24'h00_ffff;
  localparam logic [23:0] extended_special_register_area_base = 24'h00_f000;
  localparam logic [23:0] extended_special_register_area_end = 24'h00_f1ff;
  localparam logic [23:0] flash_reg_base = 24'hff_f000;
  localparam logic [23:0] flash_reg_end = 24'hff_ffff;

  // data_sram size limits per variant (window top)
  localparam logic [23:0] data_sram_end_2k = 24'h00_c7ff;

  // flash sector layout
  localparam logic [23:0] small_sector_size = 24'h00_2000;
  localparam logic [23:0] small_area_end = 24'hc0_7fff;
  localparam logic [23:0] big_sector_size = 24'h00_8000;
  localparam int block_lsb = 7;

  // undefined flash register reads
  localparam logic [15:0] trap_code = 16'h1e9b;

  // flash operation timing
  localparam int clk_hz = 10_000_000;
  localparam int prog_max_us = 5_000;
  localparam int erase_max_us = 500_000;
  localparam int prog_cycles = prog_max_us * (clk_hz / 1_000_000);
  localparam int erase_cycles = erase_max_us * (clk_hz / 1_000_000);

  typedef enum logic [1:0] {size_32k, size_64k, size_128k} flash_size_e;
  typedef enum logic [1:0] {data_sram_0k, data_sram_2k, data_sram_4k} data_sram_size_e;

  typedef enum logic [3:0] {
    reg_none, reg_flash, reg_program_sram, reg_data_sram, reg_dual_port_ram,
    reg_sfr, reg_extended_special_register_area, reg_flash_regs, reg_periph_bus
  } region_e;

  typedef enum logic [1:0] {op_read, op_write, op_erase, op_program} op_e;

  typedef struct packed {
    logic valid;
    logic fetch;
    logic word;
    op_e op;
    logic [23:0] addr;
  } cpu_req_s;

  typedef struct packed {
    logic done;
    logic trap;
    logic [15:0] rdata;
  } cpu_rsp_s;

  typedef struct packed {
    region_e region;
    logic [2:0] sector;
    logic bit_addr;
    logic data_unit;
    logic via_system_bus;
  } route_s;

endpackage

// >>> verif/cpu_model.sv
// cpu side model: issues one request at a time
// assumes the caller starts just after a rising edge of mclk
`timescale 1ns/1ns
module cpu_model (
  // clock
  input wire logic mclk,
  // request to the decoder
  output memory_map_pkg::cpu_req_s req
);
  initial req = '0;
  // valid drops after one edge so a request is never repeated
  task automatic issue(input memory_map_pkg::op_e op, input logic f, w,
    input logic [23:0] a);
  begin
    req = '{1'h1, f, w, op, a};
    @(posedge mclk);
    #1 req.valid = 1'h0;
  end
  endtask
endmodule

// >>> verif/memory_map_decoder_asserts.sv
// assertions on the memory map decoder ports
// assumes binding into memory_map_decoder, one clock domain
`timescale 1ns/1ns
module memory_map_decoder_asserts #(
  parameter int erase_count = 8
)(
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // watched ports
  input wire memory_map_pkg::cpu_req_s req,
  input wire memory_map_pkg::cpu_rsp_s rsp,
  input wire memory_map_pkg::route_s route,
  input wire logic busy,
  input wire logic [7:0] segment,
  input wire logic [1:0] data_page,
  input wire logic [3:0] gpr_index,
  input wire logic gpr_high_byte,
  input wire logic read_protect,
  input wire logic unlocked,
  input wire logic flash_reg_defined,
  input wire logic [15:0] local_rdata
);
  // --------
  // helpers
  // --------
  logic tk;
  logic rd;
  logic [31:0] bcnt;
  logic [31:0] next_bcnt;
  assign tk = req.valid && !busy;
  assign rd = tk && !req.fetch && req.op == memory_map_pkg::op_read;
  always_comb
  begin
    next_bcnt = busy ? bcnt + 32'h1 : 32'h0;
  end
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      bcnt <= 32'h0;
    else
      bcnt <= next_bcnt;
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  property p_seg;
    segment == req.addr[23:16] && data_page == req.addr[15:14];
  endproperty
  a_seg: assert property (p_seg)
    else $error("segment or page wrong");
  property p_sfr;
    rd && req.word && req.addr[23:9] == 15'h007f |=>
      !rsp.trap && rsp.rdata == $past(local_rdata);
  endproperty
  a_sfr: assert property (p_sfr)
    else $error("register area read wrong");
  property p_bit;
    req.valid && req.addr[23:8] == 16'h00fd |-> route.bit_addr;
  endproperty
  a_bit: assert property (p_bit)
    else $error("bit area not flagged");
  property p_trapc;
    rd && req.word && req.addr[23:12] == 12'hfff && !flash_reg_defined
      |=> rsp.done && rsp.rdata == 16'h1e9b;
  endproperty
  a_trapc: assert property (p_trapc)
    else $error("trap code missing");
  property p_unmap;
    tk && req.addr[23:21] == 3'h0 && req.addr[20:16] != 5'h0 |=> rsp.trap;
  endproperty
  a_unmap: assert property (p_unmap)
    else $error("unmapped access not trapped");
  property p_fetch;
    tk && req.fetch && req.addr[23:16] == 8'h00 |=> rsp.done && rsp.trap;
  endproperty
  a_fetch: assert property (p_fetch)
    else $error("data area fetch not trapped");
  property p_rprot;
    rd && req.addr[23:17] == 7'h60 && read_protect && !unlocked
      |=> rsp.trap;
  endproperty
  a_rprot: assert property (p_rprot)
    else $error("protected read not trapped");
  property p_busy;
    busy |-> !rsp.done && bcnt < erase_count;
  endproperty
  a_busy: assert property (p_busy)
    else $error("flash timing overrun");
  // register r0 sits at the bank base, low byte at the even address
  property p_gpr;
    req.valid && req.addr[23:5] == 19'h007b0 |->
      gpr_index == req.addr[4:1] &&
      gpr_high_byte == (req.addr[0] && !req.word);
  endproperty
  a_gpr: assert property (p_gpr)
    else $error("register bank view wrong");
  property p_unit;
    req.valid && !req.fetch |-> route.data_unit;
  endproperty
  a_unit: assert property (p_unit)
    else $error("data access not on data unit");
  property p_sysbus;
    req.valid && !req.fetch && req.addr[23:16] == 8'he0 &&
      req.addr[15:11] == 5'h00 |-> route.via_system_bus;
  endproperty
  a_sysbus: assert property (p_sysbus)
    else $error("program sram data access not on system bus");
  c_trap: cover property (rsp.done && rsp.trap);
  c_ok: cover property (rsp.done && !rsp.trap);
  c_busy: cover property ($fell(busy));
endmodule

bind memory_map_decoder memory_map_decoder_asserts #(
  .erase_count(erase_count)
) u_chk (.mclk, .rst, .req, .rsp, .route, .busy, .segment, .data_page,
  .gpr_index, .gpr_high_byte, .read_protect, .unlocked,
  .flash_reg_defined, .local_rdata);

// >>> verif/tb.sv
// self-checking bench for memory_map_decoder
// assumes cpu_model as partner and the bound checker
`timescale 1ns/1ns
module tb;
  localparam memory_map_pkg::op_e rd = memory_map_pkg::op_read;
  localparam memory_map_pkg::op_e wr = memory_map_pkg::op_write;
  localparam memory_map_pkg::op_e er = memory_map_pkg::op_erase;
  localparam memory_map_pkg::op_e pg = memory_map_pkg::op_program;
  logic mclk = 1'h0, rst = 1'h1, read_protect = 1'h0, unlocked = 1'h0;
  logic flash_reg_defined = 1'h0, busy;
  logic [4:0] write_protect = 5'h0;
  logic [15:0] local_rdata = 16'h0, flash_reg_rdata = 16'h0, e;
  logic [63:0] flash_line = 64'h0;
  logic [16:0] flash_block_addr;
  logic [17:0] x, exp_q[$];
  logic [23:0] bad[7] = '{24'h010000, 24'h00d000, 24'h200800,
    24'hc20000, 24'hf80000, 24'h000000, 24'h00f200};
  memory_map_pkg::flash_size_e flash_size = memory_map_pkg::size_128k;
  memory_map_pkg::data_sram_size_e data_sram_size = memory_map_pkg::data_sram_4k;
  memory_map_pkg::cpu_req_s req;
  memory_map_pkg::cpu_rsp_s rsp;
  int err_total = 0, checks = 0, n;
  always #50 mclk = ~mclk;
  cpu_model u_cpu (.mclk, .req);
  memory_map_decoder #(.prog_count(4), .erase_count(8)) u_dut (
    .mclk, .rst, .flash_size, .data_sram_size, .read_protect, .write_protect,
    .unlocked, .req, .rsp, .busy, .route(), .segment(), .data_page(),
    .gpr_index(), .gpr_high_byte(), .flash_line, .flash_reg_rdata,
    .flash_reg_defined, .local_rdata, .flash_block_addr);
  // --------
  // tasks
  // --------
  task automatic cmp(input logic [17:0] g, input logic [17:0] w);
  begin
    checks++;
    if (g !== w)
    begin
      err_total++;
      $display("[ERR] t=%0t got %h exp %h", $time, g, w);
    end
  end
  endtask
  // random read data, expected answer noted before the request
  task automatic acc(input memory_map_pkg::op_e op, input logic f, w,
    input logic [23:0] a, input logic t, input int k);
    logic [15:0] lr;
    logic [63:0] fl;
  begin
    @(posedge mclk);
    #1 lr = 16'($urandom);
    fl = {$urandom, $urandom};
    local_rdata = lr;
    flash_line = fl;
    flash_reg_rdata = ~lr;
    case (k)
      0: e = lr;
      1: e = {8'h0, a[0] ? lr[15:8] : lr[7:0]};
      2: e = fl[a[2:1]*16 +: 16];
      3: e = 16'h1e9b;
      4: e = ~lr;
      default: e = 16'h0;
    endcase
    if (busy === 1'h0)
      exp_q.push_back({k < 5, t, e});
    u_cpu.issue(op, f, w, a);
  end
  endtask
  task automatic drain;
  begin
    n = 0;
    while ((exp_q.size() != 0 || busy !== 1'h0) && n < 200)
    begin
      @(posedge mclk);
      n++;
    end
    if (n == 200)
      cmp(18'h1, 18'h0);
  end
  endtask
  task automatic print_verdict;
  begin
    $display("checks %0d errors %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  end
  endtask
  // an answer with nothing noted is a mismatch
  always @(negedge mclk)
    if (rsp.done === 1'h1)
    begin
      x = exp_q.size() != 0 ? exp_q.pop_front() : 18'h3ffff;
      cmp({x[17], rsp.trap, x[17] ? rsp.rdata : 16'h0}, x);
    end
  initial
  begin
    n = $urandom(32'h5e62);
    repeat (3) @(posedge mclk);
    #1 rst = 1'h0;
    acc(rd, 0, 1, 24'h00fe00, 0, 0);
    acc(rd, 0, 0, 24'h00f001, 0, 1);
    acc(rd, 0, 1, 24'h00fd10, 0, 0);
    acc(rd, 0, 0, 24'h00f603, 0, 1);
    acc(wr, 0, 1, 24'he00010, 0, 5);
    acc(rd, 0, 1, 24'h00c000, 0, 0);
    acc(rd, 1, 1, 24'he007fe, 0, 0);
    acc(rd, 1, 1, 24'hc1fffa, 0, 2);
    acc(rd, 1, 1, 24'h00c000, 1, 5);
    acc(rd, 0, 1, 24'hfff002, 0, 3);
    flash_reg_defined = 1'h1;
    acc(rd, 0, 1, 24'hfff002, 0, 4);
    foreach (bad[i]) acc(rd, 0, 1, bad[i], 1, 5);
    read_protect = 1'h1;
    acc(rd, 0, 1, 24'hc00000, 1, 5);
    unlocked = 1'h1;
    acc(rd, 0, 1, 24'hc00008, 0, 2);
    read_protect = 1'h0;
    unlocked = 1'h0;
    write_protect = 5'h01;
    acc(wr, 0, 1, 24'hc02000, 1, 5);
    acc(pg, 0, 1, 24'hc04080, 0, 5);
    acc(rd, 0, 1, 24'h00fe00, 0, 0);
    drain;
    cmp({1'h0, flash_block_addr}, 18'h18081);
    acc(er, 0, 1, 24'hc10000, 0, 5);
    drain;
    write_protect = 5'h10;
    acc(er, 0, 1, 24'hc18000, 1, 5);
    flash_size = memory_map_pkg::size_32k;
    data_sram_size = memory_map_pkg::data_sram_2k;
    acc(rd, 1, 1, 24'hc08000, 1, 5);
    acc(rd, 0, 1, 24'h00c800, 1, 5);
    repeat (20) acc(rd, 0, 1, {15'h007f, 8'($urandom), 1'h0}, 0, 0);
    drain;
    print_verdict;
  end
endmodule
